// File: core/sbc_defs.svh
// Purpose: Offsets, field positions, reset values and counts of the standby controller.
// Assumes: Included by bare name from the package and the design files.
// Notes: Definitions only.
`ifndef SBC_DEFS_SVH
`define SBC_DEFS_SVH
// ****************************************
// Register map
// ****************************************
`define SBC_OSC_STAB_STATUS_ADDR 16'hFFA3
`define SBC_OSC_STAB_WAIT_SELECT_ADDR 16'hFFA4
`define SBC_OSC_STAB_STATUS_RST 8'h00
`define SBC_OSC_STAB_WAIT_SELECT_RST 8'h05
`define SBC_WAIT_SEL_MSB 2
`define SBC_STATUS_FLAGS_MSB 4
`define SBC_MAIN_OSC_DISABLE_BIT 7
// ****************************************
// Stabilisation thresholds in fx cycles
// ****************************************
`define SBC_CNT_W 17
`define SBC_THR_2P11 17'h00800
`define SBC_THR_2P13 17'h02000
`define SBC_THR_2P14 17'h04000
`define SBC_THR_2P15 17'h08000
`define SBC_THR_2P16 17'h10000
`endif

// File: core/sbc_pkg.sv
// Purpose: Types of the standby controller.
// Assumes: sbc_defs.svh holds the numbers.
// Notes: Mode enum is shared by the core and the bench.
`include "sbc_defs.svh"
package sbc_pkg;
   typedef enum logic [1:0] {
      SBC_RUN = 2'b00,
      SBC_HALT = 2'b01,
      SBC_STOP = 2'b10,
      SBC_WAKE = 2'b11
   } sbc_mode_t;
endpackage

// File: core/sbc_stab_counter.sv
// Purpose: Oscillation stabilisation counter and threshold flags.
// Assumes: fx_tick_i pulses once per crystal cycle, synchronous to mclk_i.
// Notes: Counts only up to the selected threshold, then holds.
`timescale 1ns/1ns
`default_nettype none
`include "sbc_defs.svh"
module sbc_stab_counter (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic clear_i,
   input wire logic fx_tick_i,
   input wire logic [2:0] wait_sel_i,
   output logic [4:0] flags_o,
   output logic done_o
);
   import sbc_pkg::*;
   logic [`SBC_CNT_W-1:0] cnt_q;
   logic [`SBC_CNT_W-1:0] lim;

   // Maps a select code to its threshold; illegal codes give the largest.
   function automatic logic [`SBC_CNT_W-1:0] sel_limit(input logic [2:0] s);
      unique case (s)
         3'h1: sel_limit = `SBC_THR_2P11;
         3'h2: sel_limit = `SBC_THR_2P13;
         3'h3: sel_limit = `SBC_THR_2P14;
         3'h4: sel_limit = `SBC_THR_2P15;
         default: sel_limit = `SBC_THR_2P16;
      endcase
   endfunction

   assign lim = sel_limit(wait_sel_i);

   // ****************************************
   // Counter
   // ****************************************
   // Starts from zero on clear, counts fx cycles up to the limit.
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_q <= '0;
      end else if (clear_i) begin
         cnt_q <= '0;
      end else if (fx_tick_i && cnt_q < lim) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   // Flags set in order from the shortest threshold and stick until clear.
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         flags_o <= 5'h00;
         done_o <= 1'b0;
      end else if (clear_i) begin
         flags_o <= 5'h00;
         done_o <= 1'b0;
      end else begin
         flags_o <= flags_o | {cnt_q >= `SBC_THR_2P11, cnt_q >= `SBC_THR_2P13,
            cnt_q >= `SBC_THR_2P14, cnt_q >= `SBC_THR_2P15,
            cnt_q >= `SBC_THR_2P16};
         done_o <= cnt_q >= lim;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   // Flags rise in order and stick, and the count follows the qualified ticks only.
   property p_flag_order;
      @(posedge mclk_i) disable iff (!rst_b_i)
      flags_o[0] |-> &flags_o[4:1];
   endproperty
   a_flag_order: assert property (p_flag_order) else $error("flags not in order");
   property p_cap;
      @(posedge mclk_i) disable iff (!rst_b_i)
      cnt_q <= lim;
   endproperty
   a_cap: assert property (p_cap) else $error("counter passed limit");
   property p_sticky;
      @(posedge mclk_i) disable iff (!rst_b_i)
      !clear_i |=> (flags_o & $past(flags_o)) == $past(flags_o);
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag fell without clear");
   property p_clear;
      @(posedge mclk_i) disable iff (!rst_b_i)
      clear_i |=> cnt_q == 17'h00000 && flags_o == 5'h00;
   endproperty
   a_clear: assert property (p_clear) else $error("clear did not restart count");
   property p_step;
      @(posedge mclk_i) disable iff (!rst_b_i)
      fx_tick_i && !clear_i && cnt_q < lim |=> cnt_q == $past(cnt_q) + 17'h00001;
   endproperty
   a_step: assert property (p_step) else $error("count missed a tick");
   property p_no_tick;
      @(posedge mclk_i) disable iff (!rst_b_i)
      !fx_tick_i && !clear_i |=> cnt_q == $past(cnt_q);
   endproperty
   a_no_tick: assert property (p_no_tick) else $error("count moved without tick");
endmodule
`default_nettype wire

// File: core/sbc_standby_ctrl.sv
// Purpose: HALT and STOP standby control with oscillation stabilisation wait.
// Assumes: CPU strobes are one-cycle pulses; crystal_run_i marks real oscillation.
// Notes: Register access uses the CPU's internal address, data and strobes.
`timescale 1ns/1ns
`default_nettype none
`include "sbc_defs.svh"
module sbc_standby_ctrl (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic halt_exec_i,
   input wire logic stop_exec_i,
   input wire logic irq_req_i,
   input wire logic cpu_on_crystal_i,
   input wire logic crystal_run_i,
   input wire logic fx_tick_i,
   input wire logic main_osc_disable_i,
   input wire logic [15:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic byte_acc_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   output logic cpu_clk_en_o,
   output logic crystal_osc_en_o,
   output logic int_hs_osc_en_o,
   output logic state_hold_o,
   output var sbc_pkg::sbc_mode_t mode_o
);
   import sbc_pkg::*;
   sbc_mode_t mode_q;
   logic [7:0] wait_sel_q;
   logic [4:0] flags;
   logic done;
   logic clr;
   logic osc_run;

   // True while the main oscillators must be off: in STOP, or as STOP is taken.
   // Both oscillator enables use it, so they can never disagree.
   function automatic logic osc_stopped(input sbc_mode_t m, input logic stop);
      osc_stopped = m == SBC_STOP || (m == SBC_RUN && stop);
   endfunction

   // ****************************************
   // Mode sequencing
   // ****************************************
   // HALT and STOP leave on an interrupt; a crystal CPU leaving STOP waits out the time.
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mode_q <= SBC_RUN;
      end else begin
         unique case (mode_q)
            SBC_RUN: begin
               if (stop_exec_i) mode_q <= SBC_STOP;
               else if (halt_exec_i) mode_q <= SBC_HALT;
            end
            SBC_HALT: if (irq_req_i) mode_q <= SBC_RUN;
            SBC_STOP: if (irq_req_i) mode_q <= cpu_on_crystal_i ? SBC_WAKE : SBC_RUN;
            SBC_WAKE: if (done) mode_q <= SBC_RUN;
         endcase
      end
   end

   // Clock and hold outputs derived from the current mode, the standby strobes and the interrupt request, registered.
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cpu_clk_en_o <= 1'b1;
         crystal_osc_en_o <= 1'b1;
         int_hs_osc_en_o <= 1'b1;
         state_hold_o <= 1'b0;
         mode_o <= SBC_RUN;
      end else begin
         cpu_clk_en_o <= (mode_q == SBC_RUN) && !halt_exec_i && !stop_exec_i;
         crystal_osc_en_o <= !osc_stopped(mode_q, stop_exec_i) || irq_req_i;
         int_hs_osc_en_o <= !osc_stopped(mode_q, stop_exec_i) || irq_req_i;
         state_hold_o <= mode_q != SBC_RUN || halt_exec_i || stop_exec_i;
         mode_o <= mode_q;
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   // Select register takes byte writes only.
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wait_sel_q <= `SBC_OSC_STAB_WAIT_SELECT_RST;
      end else if (wr_i && byte_acc_i && addr_i == `SBC_OSC_STAB_WAIT_SELECT_ADDR) begin
         wait_sel_q <= {5'h00, wdata_i[`SBC_WAIT_SEL_MSB:0]};
      end
   end

   // Read data; the status register ignores writes of either width.
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i) begin
         if (addr_i == `SBC_OSC_STAB_STATUS_ADDR) rdata_o <= {3'h0, flags};
         else if (addr_i == `SBC_OSC_STAB_WAIT_SELECT_ADDR) rdata_o <= wait_sel_q;
         else rdata_o <= 8'h00;
      end
   end

   assign clr = stop_exec_i || main_osc_disable_i || mode_q == SBC_STOP;
   assign osc_run = fx_tick_i && crystal_run_i;

   sbc_stab_counter u_cnt (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .clear_i(clr),
      .fx_tick_i(osc_run),
      .wait_sel_i(wait_sel_q[2:0]),
      .flags_o(flags),
      .done_o(done)
   );

   // ****************************************
   // Checks
   // ****************************************
   // Clock gating and oscillator enables follow the mode one edge later.
   property p_halt_gate;
      @(posedge mclk_i) disable iff (!rst_b_i)
      mode_q == SBC_HALT |=> !cpu_clk_en_o;
   endproperty
   a_halt_gate: assert property (p_halt_gate) else $error("cpu clock in halt");
   property p_run_clk;
      @(posedge mclk_i) disable iff (!rst_b_i)
      mode_q == SBC_RUN && !halt_exec_i && !stop_exec_i |=> cpu_clk_en_o;
   endproperty
   a_run_clk: assert property (p_run_clk) else $error("cpu clock off in run");
   property p_halt_osc;
      @(posedge mclk_i) disable iff (!rst_b_i)
      mode_q == SBC_HALT |=> crystal_osc_en_o && int_hs_osc_en_o;
   endproperty
   a_halt_osc: assert property (p_halt_osc) else $error("osc off in halt");
   property p_stop_osc;
      @(posedge mclk_i) disable iff (!rst_b_i)
      mode_q == SBC_STOP && !irq_req_i |=> !crystal_osc_en_o && !int_hs_osc_en_o;
   endproperty
   a_stop_osc: assert property (p_stop_osc) else $error("osc on in stop");
   // Release from STOP, straight to run or through the crystal wait.
   property p_stop_exit;
      @(posedge mclk_i) disable iff (!rst_b_i)
      mode_q == SBC_STOP && irq_req_i |=> mode_q != SBC_STOP;
   endproperty
   a_stop_exit: assert property (p_stop_exit) else $error("stop not released");
   property p_stop_int;
      @(posedge mclk_i) disable iff (!rst_b_i)
      mode_q == SBC_STOP && irq_req_i && !cpu_on_crystal_i |=> mode_q == SBC_RUN;
   endproperty
   a_stop_int: assert property (p_stop_int) else $error("internal clock not resumed");
   property p_wake;
      @(posedge mclk_i) disable iff (!rst_b_i)
      mode_q == SBC_WAKE |=> !cpu_clk_en_o;
   endproperty
   a_wake: assert property (p_wake) else $error("cpu ran during wait");
   property p_wake_exit;
      @(posedge mclk_i) disable iff (!rst_b_i)
      mode_q == SBC_WAKE && done |=> mode_q == SBC_RUN;
   endproperty
   a_wake_exit: assert property (p_wake_exit) else $error("wait not ended");
   // State is frozen in standby and free again in run.
   property p_hold;
      @(posedge mclk_i) disable iff (!rst_b_i)
      mode_q != SBC_RUN |=> state_hold_o;
   endproperty
   a_hold: assert property (p_hold) else $error("state not held");
   property p_run_hold;
      @(posedge mclk_i) disable iff (!rst_b_i)
      mode_q == SBC_RUN && !halt_exec_i && !stop_exec_i |=> !state_hold_o;
   endproperty
   a_run_hold: assert property (p_run_hold) else $error("state held in run");
   // Register reads, writes and status clearing.
   property p_ro;
      @(posedge mclk_i) disable iff (!rst_b_i)
      rd_i && addr_i == `SBC_OSC_STAB_STATUS_ADDR |=> rdata_o[7:5] == 3'h0;
   endproperty
   a_ro: assert property (p_ro) else $error("status high bits set");
   property p_rd_status;
      @(posedge mclk_i) disable iff (!rst_b_i)
      rd_i && addr_i == `SBC_OSC_STAB_STATUS_ADDR |=> rdata_o == {3'h0, $past(flags)};
   endproperty
   a_rd_status: assert property (p_rd_status) else $error("status read wrong");
   property p_clr;
      @(posedge mclk_i) disable iff (!rst_b_i)
      stop_exec_i |=> ##1 flags == 5'h00;
   endproperty
   a_clr: assert property (p_clr) else $error("status not cleared");
   property p_dis_clr;
      @(posedge mclk_i) disable iff (!rst_b_i)
      main_osc_disable_i |=> flags == 5'h00;
   endproperty
   a_dis_clr: assert property (p_dis_clr) else $error("status kept on disable");
   property p_wr;
      @(posedge mclk_i) disable iff (!rst_b_i)
      wr_i && !byte_acc_i |=> $stable(wait_sel_q);
   endproperty
   a_wr: assert property (p_wr) else $error("bit write changed select");
   property p_wr_sel;
      @(posedge mclk_i) disable iff (!rst_b_i)
      wr_i && byte_acc_i && addr_i == `SBC_OSC_STAB_WAIT_SELECT_ADDR
         |=> wait_sel_q == ($past(wdata_i) & 8'h07);
   endproperty
   a_wr_sel: assert property (p_wr_sel) else $error("byte write lost");
   // Main scenarios worth seeing at least once.
   c_halt: cover property (@(posedge mclk_i) mode_q == SBC_HALT ##1 mode_q == SBC_RUN);
   c_wake: cover property (@(posedge mclk_i) mode_q == SBC_WAKE ##1 mode_q == SBC_RUN);
   c_poll: cover property (@(posedge mclk_i) mode_q == SBC_RUN && flags[4]);
   c_stop_int: cover property (@(posedge mclk_i)
      mode_q == SBC_STOP && irq_req_i && !cpu_on_crystal_i);
endmodule
`default_nettype wire

// File: test/sbc_cpu_model.sv
// Purpose: CPU core model issuing standby instructions and register accesses.
// Assumes: Each request rises 1 ns after an edge and is held through one taking edge.
// Notes: Software duties of the core are kept by the sequences that call these tasks.
`timescale 1ns/1ns
`default_nettype none
module sbc_cpu_model (
   input wire logic mclk_i,
   input wire logic [7:0] rdata_i,
   output logic halt_o,
   output logic stop_o,
   output logic [15:0] addr_o,
   output logic [7:0] wdata_o,
   output logic wr_o,
   output logic byte_acc_o,
   output logic rd_o
);
   // The bus starts idle with byte accesses selected.
   initial begin
      {halt_o, stop_o, wr_o, rd_o} = 4'h0;
      addr_o = 16'h0000;
      wdata_o = 8'h00;
      byte_acc_o = 1'b1;
   end
   // One strobe held over one taking edge; released data is inverted so it never lingers.
   task automatic op(input logic [3:0] k, input logic [15:0] a, input logic [7:0] d,
                     input logic b);
      @(posedge mclk_i);
      #1;
      {halt_o, stop_o, wr_o, rd_o} = k;
      addr_o = a;
      wdata_o = d;
      byte_acc_o = b;
      @(posedge mclk_i);
      #1;
      {halt_o, stop_o, wr_o, rd_o} = 4'h0;
      wdata_o = ~d;
   endtask
   // A byte read; data is taken one edge after the strobe.
   task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
      op(4'h1, a, 8'h00, 1'b1);
      @(posedge mclk_i);
      #1;
      d = rdata_i;
   endtask
endmodule
`default_nettype wire

// File: test/sbc_standby_ctrl_tb.sv
// Purpose: Self-checking bench of the standby controller.
// Assumes: fx ticks every cycle while enabled, so thresholds are counted in mclk cycles.
// Notes: Short waits use select code 001 and 010.
`timescale 1ns/1ns
`default_nettype none
`include "sbc_defs.svh"
module sbc_standby_ctrl_tb;
   import sbc_pkg::*;
   localparam logic [15:0] ST = `SBC_OSC_STAB_STATUS_ADDR;
   localparam logic [15:0] SL = `SBC_OSC_STAB_WAIT_SELECT_ADDR;
   logic mclk = 1'b0, rst_b = 1'b0, irq = 1'b0, on_xtal = 1'b1, xrun = 1'b1, osc_dis = 1'b0;
   logic halt, stop, wr, byte_acc, rd, clk_en, xtal_en, ihs_en, hold;
   logic [15:0] addr;
   logic [7:0] wdata, rdata, d;
   sbc_mode_t mode;
   int miscompares = 0, comparisons = 0, n;
   time t0;
   sbc_cpu_model sbc_cpu_model_inst (.mclk_i(mclk), .rdata_i(rdata), .halt_o(halt),
      .stop_o(stop), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .byte_acc_o(byte_acc),
      .rd_o(rd));
   sbc_standby_ctrl sbc_standby_ctrl_inst (.mclk_i(mclk), .rst_b_i(rst_b), .halt_exec_i(halt),
      .stop_exec_i(stop), .irq_req_i(irq), .cpu_on_crystal_i(on_xtal), .crystal_run_i(xrun),
      .fx_tick_i(xtal_en), .main_osc_disable_i(osc_dis), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .byte_acc_i(byte_acc), .rd_i(rd), .rdata_o(rdata), .cpu_clk_en_o(clk_en),
      .crystal_osc_en_o(xtal_en), .int_hs_osc_en_o(ihs_en), .state_hold_o(hold), .mode_o(mode));
   // Clock of 20 ns period.
   initial begin
      forever #10 mclk = ~mclk;
   end
   // Compares a value seen with the value expected and counts both outcomes.
   task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic rd_chk(input string nm, input logic [15:0] a, input logic [7:0] exp);
      sbc_cpu_model_inst.rd_reg(a, d);
      chk(nm, d, exp);
   endtask
   task automatic wr_reg(input logic [15:0] a, input logic [7:0] v, input logic b);
      sbc_cpu_model_inst.op(4'h2, a, v, b);
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask
   // Counts cycles until the CPU clock is back, bounded.
   task automatic wait_run();
      n = 0;
      while (clk_en !== 1'b1 && n < 20000) begin
         cyc(1);
         n++;
      end
   endtask
   task automatic finish_test();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Watchdog sized well above the longest wait.
   initial begin
      #(40000 * 20);
      miscompares++;
      finish_test();
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      cyc(5);
      rst_b = 1'b1;
      rd_chk("status", ST, 8'h00);
      rd_chk("select", SL, 8'h05);
      wr_reg(SL, 8'h01, 1'b0);
      rd_chk("select", SL, 8'h05);
      wr_reg(ST, 8'hFF, 1'b1);
      rd_chk("status", ST, 8'h00);
      rd_chk("unmapped", 16'hFFA5, 8'h00);
      wr_reg(SL, 8'h01, 1'b1);
      rd_chk("select", SL, 8'h01);
      $display("test registers done");
      sbc_cpu_model_inst.op(4'h8, 16'h0000, 8'h00, 1'b1);
      cyc(3);
      chk("halt clk", {7'h00, clk_en}, 8'h00);
      chk("halt osc", {6'h00, xtal_en, ihs_en}, 8'h03);
      chk("halt hold", {7'h00, hold}, 8'h01);
      chk("halt mode", {6'h00, mode}, {6'h00, SBC_HALT});
      irq = 1'b1;
      wait_run();
      irq = 1'b0;
      chk("halt exit", {7'h00, n < 10}, 8'h01);
      chk("run hold", {7'h00, hold}, 8'h00);
      $display("test halt done");
      sbc_cpu_model_inst.op(4'h4, 16'h0000, 8'h00, 1'b1);
      cyc(3);
      chk("stop osc", {6'h00, xtal_en, ihs_en}, 8'h00);
      chk("stop mode", {6'h00, mode}, {6'h00, SBC_STOP});
      xrun = 1'b0;
      irq = 1'b1;
      cyc(20);
      chk("wake xtal", {7'h00, xtal_en}, 8'h01);
      chk("no count", {7'h00, clk_en}, 8'h00);
      xrun = 1'b1;
      wait_run();
      irq = 1'b0;
      chk("xtal wait", {7'h00, n >= 2048 && n <= 2056}, 8'h01);
      rd_chk("status", ST, 8'h10);
      $display("test stop crystal done");
      wr_reg(SL, 8'h02, 1'b1);
      on_xtal = 1'b0;
      sbc_cpu_model_inst.op(4'h4, 16'h0000, 8'h00, 1'b1);
      cyc(3);
      irq = 1'b1;
      cyc(3);
      irq = 1'b0;
      t0 = $time;
      chk("int run", {7'h00, clk_en}, 8'h01);
      d = 8'h00;
      while (d !== 8'h18 && ($time - t0) < 400000) begin
         sbc_cpu_model_inst.rd_reg(ST, d);
      end
      chk("poll time", {7'h00, ($time - t0) >= 8192 * 20}, 8'h01);
      cyc(300);
      rd_chk("status", ST, 8'h18);
      $display("test stop internal done");
      osc_dis = 1'b1;
      cyc(2);
      rd_chk("status", ST, 8'h00);
      osc_dis = 1'b0;
      $display("test disable done");
      // A reset in mid-run must bring the select register back to its default.
      rd_chk("select", SL, 8'h02);
      rst_b = 1'b0;
      cyc(2);
      rst_b = 1'b1;
      chk("reset clk", {7'h00, clk_en}, 8'h01);
      rd_chk("select", SL, 8'h05);
      rd_chk("status", ST, 8'h00);
      $display("test reset done");
      finish_test();
   end
endmodule
`default_nettype wire
